// ==== verilog/ec_ctrl_irq.sv ====
// Operation
// - each canceller raises one event on tone-disable start and one on release
// - every pending event is queued in a fifo holding the channel number
// - interrupt line returns high after every read of the fifo register
// - interrupt line goes low again for each entry still queued
// - global mask bit 5 of main control register 0 masks all interrupts
// - main control bits 4 and 3 mask tone events of cancellers B and A
// - control bit 7 runs init: presets register, clears coefficients
// - control bit 6 disables comfort noise injection
// - control bit 5 selects back-to-back configuration
// - control bit 4 inserts 12dB attenuation on receive path
// - control bit 3 bypasses both paths, zeroes coefficients, stops adaptation
// - control bit 2 freezes adaptation while cancellation continues
// - bit 0 of register A cascades the group into one 128ms canceller
// - in bypass both paths delay data exactly two frames
// - reset clears the fifo and all sixteen main control registers
`timescale 1ns/1ps
module ec_ctrl_irq (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CS_N_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic [ec_ctrl_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_OUT,
  output logic ACK_N_OUT,
  output logic HOST_INTERRUPT_N_OUT,
  input wire logic [ec_ctrl_pkg::NUM_CH-1:0] TONE_DET_IN,
  output logic [ec_ctrl_pkg::NUM_CH-1:0] NOISE_INJECT_OFF_OUT,
  output logic [ec_ctrl_pkg::NUM_CH-1:0] BACK_TO_BACK_SEL_OUT,
  output logic [ec_ctrl_pkg::NUM_CH-1:0] RX_ATTENUATE_OUT,
  output logic [ec_ctrl_pkg::NUM_CH-1:0] BYPASS_OUT,
  output logic [ec_ctrl_pkg::NUM_CH-1:0] ADAPT_FREEZE_OUT,
  output logic [ec_ctrl_pkg::NUM_CH-1:0] COEF_CLEAR_OUT,
  output logic [ec_ctrl_pkg::NUM_GRP-1:0] CASCADE_LONG_TAIL_OUT,
  input wire logic PCM_STB_IN,
  input wire logic [ec_ctrl_pkg::CH_W-1:0] PCM_CH_IN,
  input wire logic [7:0] RIN_IN,
  input wire logic [7:0] SIN_IN,
  input wire logic [7:0] ALGO_ROUT_IN,
  input wire logic [7:0] ALGO_SOUT_IN,
  output logic [7:0] ROUT_OUT,
  output logic [7:0] SOUT_OUT
);
  import ec_ctrl_pkg::*;

  function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] v);
    logic [CH_W-1:0] idx;
    idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (v[i])
        idx = CH_W'(i);
    return idx;
  endfunction

  logic [7:0] ctrl_r [NUM_CH];
  logic [7:0] main_r [NUM_GRP];
  logic [2:0] cs_sync_r;
  logic [2:0] rd_sync_r;
  logic [2:0] wr_sync_r;
  logic acc_d_r;
  logic acc;
  logic start;
  logic is_wr;
  logic [7:0] rd_mux;
  logic [CH_W-1:0] a_ch;
  logic fifo_rd;
  logic [NUM_CH-1:0] tone_d_r;
  logic [NUM_CH-1:0] pend_r;
  logic [NUM_CH-1:0] ev_on;
  logic [NUM_CH-1:0] ch_mask;
  logic [CH_W-1:0] pick;
  logic gmask;
  logic [7:0] data_r;
  logic oe_r;
  logic ack_n_r;
  logic irq_n_r;
  logic [NUM_CH-1:0] clear_r;
  logic [NUM_GRP-1:0] casc;
  logic [7:0] rin_m1 [NUM_CH];
  logic [7:0] rin_m2 [NUM_CH];
  logic [7:0] sin_m1 [NUM_CH];
  logic [7:0] sin_m2 [NUM_CH];
  logic [7:0] rout_r;
  logic [7:0] sout_r;

  irq_fifo_if #(.DW(CH_W)) fq ();

  irq_fifo #(.DEPTH(FIFO_DEPTH), .DW(CH_W)) u_fifo (
    .clk(SYS_CLK_IN),
    .rst_n(RSTN_IN),
    .f(fq.store)
  );

  // host strobes come from pins; only the second stage is read, the third is never used
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      cs_sync_r <= 3'h7;
      rd_sync_r <= 3'h7;
      wr_sync_r <= 3'h7;
      acc_d_r <= 1'b0;
    end
    else
    begin
      cs_sync_r <= {cs_sync_r[1:0], CS_N_IN};
      rd_sync_r <= {rd_sync_r[1:0], RD_N_IN};
      wr_sync_r <= {wr_sync_r[1:0], WR_N_IN};
      acc_d_r <= acc;
    end
  end

  assign acc = !cs_sync_r[1] && (!rd_sync_r[1] || !wr_sync_r[1]);
  assign start = acc && !acc_d_r;
  assign is_wr = !wr_sync_r[1];
  assign a_ch = ADDR_IN[9:5];
  assign fifo_rd = start && !is_wr && (ADDR_IN == FIFO_ADDR);
  assign gmask = main_r[0][MAIN_GMASK];

  always_comb
  begin
    rd_mux = 8'h00;
    if (ADDR_IN == FIFO_ADDR)
      rd_mux = fq.empty ? 8'h00 : {1'b1, 2'b00, fq.pop_data};
    else if (ADDR_IN[10] && ADDR_IN[9:4] == 6'h00)
      rd_mux = main_r[ADDR_IN[3:0]];
    else if (!ADDR_IN[10] && ADDR_IN[4:0] == OFF_CTRL)
      rd_mux = ctrl_r[a_ch];
    else if (!ADDR_IN[10] && ADDR_IN[4:0] == OFF_STATUS)
      rd_mux = {7'h00, tone_d_r[a_ch]};
  end

  // control registers; init bit self-clears by presetting the register
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      for (int i = 0; i < NUM_CH; i++)
        ctrl_r[i] <= CTRL_RST;
      for (int g = 0; g < NUM_GRP; g++)
        main_r[g] <= MAIN_RST;
      clear_r <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
        clear_r[i] <= ctrl_r[i][CTL_BYPASS];
      if (start && is_wr && !ADDR_IN[10] && ADDR_IN[4:0] == OFF_CTRL)
      begin
        if (DATA_IN[CTL_INIT])
        begin
          ctrl_r[a_ch] <= CTRL_RST;
          clear_r[a_ch] <= 1'b1;
        end
        else
          ctrl_r[a_ch] <= DATA_IN;
      end
      else if (start && is_wr && ADDR_IN[10] && ADDR_IN[9:4] == 6'h00)
        main_r[ADDR_IN[3:0]] <= DATA_IN;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      ch_mask[i] = main_r[i/2][i[0] ? MAIN_MASK_B : MAIN_MASK_A];
    for (int g = 0; g < NUM_GRP; g++)
      casc[g] = ctrl_r[2*g][CTL_CASCADE];
  end

  // any edge of the tone flag on an unmasked channel is an event; set wins over the push clear
  assign ev_on = (TONE_DET_IN ^ tone_d_r) & ~ch_mask;
  assign pick = first_set(pend_r);
  assign fq.push = |pend_r;
  assign fq.push_data = pick;
  assign fq.pop = fifo_rd;

  // a second edge while one is pending is held back, and pend stays set while it is held
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      tone_d_r <= '0;
      pend_r <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (!(ev_on[i] && pend_r[i]))
          tone_d_r[i] <= TONE_DET_IN[i];
        if (ev_on[i])
          pend_r[i] <= 1'b1;
        else if (!fq.full && CH_W'(i) == pick)
          pend_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      data_r <= 8'h00;
      oe_r <= 1'b0;
      ack_n_r <= 1'b1;
      irq_n_r <= 1'b1;
    end
    else
    begin
      if (start && !is_wr)
        data_r <= rd_mux;
      oe_r <= acc && !is_wr;
      ack_n_r <= !(acc && acc_d_r);
      if (fifo_rd)
        irq_n_r <= 1'b1;
      else
        irq_n_r <= fq.empty || gmask;
    end
  end

  // bypass pipeline: two stored frames per channel and path
  // cleared on reset so the first bypassed frames never carry unknowns
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        rin_m1[i] <= 8'h00;
        rin_m2[i] <= 8'h00;
        sin_m1[i] <= 8'h00;
        sin_m2[i] <= 8'h00;
      end
    end
    else if (PCM_STB_IN)
    begin
      rin_m1[PCM_CH_IN] <= RIN_IN;
      rin_m2[PCM_CH_IN] <= rin_m1[PCM_CH_IN];
      sin_m1[PCM_CH_IN] <= SIN_IN;
      sin_m2[PCM_CH_IN] <= sin_m1[PCM_CH_IN];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rout_r <= 8'h00;
      sout_r <= 8'h00;
    end
    else if (PCM_STB_IN)
    begin
      if (ctrl_r[PCM_CH_IN][CTL_BYPASS])
      begin
        rout_r <= rin_m2[PCM_CH_IN];
        sout_r <= sin_m2[PCM_CH_IN];
      end
      else
      begin
        rout_r <= ALGO_ROUT_IN;
        sout_r <= ALGO_SOUT_IN;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      NOISE_INJECT_OFF_OUT[i] = ctrl_r[i][CTL_NOISE_OFF];
      BACK_TO_BACK_SEL_OUT[i] = ctrl_r[i][CTL_B2B];
      RX_ATTENUATE_OUT[i] = ctrl_r[i][CTL_ATTEN];
      BYPASS_OUT[i] = ctrl_r[i][CTL_BYPASS];
      ADAPT_FREEZE_OUT[i] = ctrl_r[i][CTL_FREEZE];
    end
  end

  assign COEF_CLEAR_OUT = clear_r;
  assign CASCADE_LONG_TAIL_OUT = casc;
  assign DATA_OUT = data_r;
  assign DATA_OE_OUT = oe_r;
  assign ACK_N_OUT = ack_n_r;
  assign HOST_INTERRUPT_N_OUT = irq_n_r;
  assign ROUT_OUT = rout_r;
  assign SOUT_OUT = sout_r;

  a_irq_release: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    fifo_rd |=> HOST_INTERRUPT_N_OUT)
    else $error("interrupt not released after fifo read");
  a_irq_again: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    !fq.empty && !gmask && !fifo_rd |=> !HOST_INTERRUPT_N_OUT)
    else $error("interrupt not driven for queued entry");
  a_gmask_all: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    gmask |=> HOST_INTERRUPT_N_OUT)
    else $error("interrupt seen while globally masked");
  a_ch_masked: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ch_mask[8] && !pend_r[8] |=> !pend_r[8])
    else $error("masked channel raised an event");
  a_edge_pend: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ev_on[3] |=> pend_r[3])
    else $error("tone edge not held pending");
  a_pend_queue: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    |pend_r && !fq.full |-> fq.push && pend_r[fq.push_data])
    else $error("pending event not queued");
  a_init_clear: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    start && is_wr && !ADDR_IN[10] && ADDR_IN[4:0] == OFF_CTRL && DATA_IN[7]
    |=> ctrl_r[$past(a_ch)] == CTRL_RST && COEF_CLEAR_OUT[$past(a_ch)])
    else $error("init did not preset register");
  a_bypass_coef: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    BYPASS_OUT[3] |=> COEF_CLEAR_OUT[3])
    else $error("bypass did not clear coefficients");
  a_bypass_delay: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    PCM_STB_IN && ctrl_r[PCM_CH_IN][CTL_BYPASS]
    |=> ROUT_OUT == $past(rin_m2[PCM_CH_IN]))
    else $error("bypass receive delay wrong");
endmodule

// ==== include/ec_ctrl_pkg.sv ====
package ec_ctrl_pkg;
  localparam int NUM_CH = 32;
  localparam int NUM_GRP = 16;
  localparam int ADDR_W = 11;
  localparam int CH_W = 5;
  // per-channel window of 32 bytes: base = channel * 0x20
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h02;
  localparam logic [ADDR_W-1:0] MAIN_BASE = 11'h400;
  localparam logic [ADDR_W-1:0] FIFO_ADDR = 11'h410;
  // canceller control register fields
  localparam int CTL_INIT = 7;
  localparam int CTL_NOISE_OFF = 6;
  localparam int CTL_B2B = 5;
  localparam int CTL_ATTEN = 4;
  localparam int CTL_BYPASS = 3;
  localparam int CTL_FREEZE = 2;
  localparam int CTL_CASCADE = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // main control register fields
  localparam int MAIN_GMASK = 5;
  localparam int MAIN_MASK_B = 4;
  localparam int MAIN_MASK_A = 3;
  localparam logic [7:0] MAIN_RST = 8'h00;
  // status and fifo read fields
  localparam int STAT_TONE = 0;
  localparam int FIFO_VALID = 7;
  // two events per canceller may be waiting
  localparam int FIFO_DEPTH = 2 * NUM_CH;
  localparam int BYPASS_FRAMES = 2;
endpackage

// ==== include/irq_fifo_if.sv ====
`timescale 1ns/1ps
interface irq_fifo_if #(parameter int DW = 5);
  logic push;
  logic [DW-1:0] push_data;
  logic full;
  logic pop;
  logic [DW-1:0] pop_data;
  logic empty;
  modport store (input push, push_data, pop, output full, pop_data, empty);
  modport user (output push, push_data, pop, input full, pop_data, empty);
endinterface

// ==== verilog/irq_fifo.sv ====
`timescale 1ns/1ps
module irq_fifo #(
  parameter int DEPTH = ec_ctrl_pkg::FIFO_DEPTH,
  parameter int DW = ec_ctrl_pkg::CH_W
) (
  input wire logic clk,
  input wire logic rst_n,
  irq_fifo_if.store f
);
  import ec_ctrl_pkg::*;
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("irq_fifo depth must be a power of two");
  end

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  assign f.full = (count_r == (AW+1)'(DEPTH));
  assign f.empty = (count_r == '0);
  assign f.pop_data = mem[rd_ptr_r];

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_r] <= f.push_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_push && !do_pop)
        count_r <= count_r + 1'b1;
      else if (do_pop && !do_push)
        count_r <= count_r - 1'b1;
    end
  end

  a_fifo_count: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !do_pop |=> count_r == $past(count_r) + 1'b1)
    else $error("fifo count did not grow on push");
  a_fifo_order: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && f.empty |=> f.pop_data == $past(f.push_data))
    else $error("first entry not at fifo head");
endmodule

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic ack_n,
  input wire logic [7:0] rdata,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [ec_ctrl_pkg::ADDR_W-1:0] addr,
  output logic [7:0] wdata
);
  import ec_ctrl_pkg::*;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = '0;
    wdata = 8'h00;
  end
  // request held until ack is sampled low or 20 cycles pass, then all released together
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'hxx;
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= wr;
    wr_n <= ~wr;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack_n !== 1'b0 && n < 20);
    if (ack_n === 1'b0)
      q = rdata;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // released lines show the inverse, never a stale value
    addr <= ~a;
    wdata <= ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== bench/ec_ctrl_irq_bench.sv ====
`timescale 1ns/1ps
module ec_ctrl_irq_bench;
  import ec_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, rd_n, wr_n, ack_n, irq_n;
  logic irq_q = 1'b1;
  logic stb = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, rout, sout;
  logic [7:0] rin = 8'h00;
  logic [7:0] sin = 8'h00;
  logic [4:0] pch = 5'h00;
  logic [NUM_CH-1:0] tone = '0;
  logic [NUM_CH-1:0] nio, b2b, att, byp, frz;
  logic [NUM_GRP-1:0] casc;
  logic [NUM_CH-1:0] coef;
  logic oe;
  int failures = 0;
  int checked = 0;
  int falls = 0;

  initial forever #50 clk = ~clk;

  host_model host_u (.clk(clk), .ack_n(ack_n), .rdata(rdata), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata));

  ec_ctrl_irq dut_u (
    .SYS_CLK_IN(clk), .RSTN_IN(rst_n), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .ADDR_IN(addr), .DATA_IN(wdata), .DATA_OUT(rdata),
    .DATA_OE_OUT(oe), .ACK_N_OUT(ack_n), .HOST_INTERRUPT_N_OUT(irq_n),
    .TONE_DET_IN(tone), .NOISE_INJECT_OFF_OUT(nio),
    .BACK_TO_BACK_SEL_OUT(b2b), .RX_ATTENUATE_OUT(att), .BYPASS_OUT(byp),
    .ADAPT_FREEZE_OUT(frz), .COEF_CLEAR_OUT(coef),
    .CASCADE_LONG_TAIL_OUT(casc), .PCM_STB_IN(stb), .PCM_CH_IN(pch),
    .RIN_IN(rin), .SIN_IN(sin), .ALGO_ROUT_IN(8'ha5),
    .ALGO_SOUT_IN(8'h5a), .ROUT_OUT(rout), .SOUT_OUT(sout));

  always @(posedge clk)
  begin
    irq_q <= irq_n;
    if (irq_q === 1'b1 && irq_n === 1'b0)
      falls <= falls + 1;
  end

  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host_u.access(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  // 40 cycles lets a full burst of 32 edges reach the queue
  task automatic set_tone(input logic [NUM_CH-1:0] v);
    @(posedge clk);
    tone <= v;
    repeat (40) @(posedge clk);
    #1;
  endtask

  task automatic pcm(input logic [4:0] c, input logic [7:0] r,
    input logic [7:0] er, input logic on);
    @(posedge clk);
    stb <= 1'b1;
    pch <= c;
    rin <= r;
    sin <= ~r;
    @(posedge clk);
    stb <= 1'b0;
    rin <= ~r;
    sin <= r;
    #1;
    if (on)
    begin
      chk(rout, er);
      chk(sout, (er == 8'ha5) ? 8'h5a : ~er);
    end
  endtask

  task automatic t_ctrl;
    wr(11'h040, 8'h5c);
    wr(11'h080, 8'h01);
    wr(11'h0c0, 8'h20);
    wr(11'h0e0, 8'h20);
    rd(11'h040, 8'h5c);
    chk({4'h0, nio[2], att[2], byp[2], frz[2]}, 8'h0f);
    chk({4'h0, casc[2], casc[3], b2b[7], b2b[6]}, 8'h0b);
    chk({7'h00, coef[2]}, 8'h01);
    chk({7'h00, oe}, 8'h00);
    $display("control test done");
  endtask

  task automatic t_init;
    wr(11'h040, 8'h80);
    rd(11'h040, 8'h00);
    chk({4'h0, nio[2], att[2], byp[2], frz[2]}, 8'h00);
    $display("init test done");
  endtask

  task automatic t_reset;
    wr(MAIN_BASE + 11'h004, 8'h18);
    rd(MAIN_BASE + 11'h004, 8'h18);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(MAIN_BASE + 11'h004, 8'h00);
    rd(11'h0e0, 8'h00);
    rd(FIFO_ADDR, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    $display("reset test done");
  endtask

  task automatic t_pcm;
    wr(11'h060, 8'h08);
    for (logic [7:0] v = 8'h10; v < 8'h15; v++)
      pcm(5'd3, v, v - 8'h02, v > 8'h11);
    wr(11'h060, 8'h00);
    pcm(5'd3, 8'h33, 8'ha5, 1'b1);
    pcm(5'd2, 8'h44, 8'ha5, 1'b1);
    $display("pcm test done");
  endtask

  task automatic t_depth;
    set_tone('1);
    set_tone('0);
    for (int i = 0; i < 64; i++)
      rd(FIFO_ADDR, {3'b100, i[4:0]});
    rd(FIFO_ADDR, 8'h00);
    $display("depth test done");
  endtask

  task automatic t_irq;
    int f0;
    f0 = falls;
    set_tone(32'h0000_1200);
    chk({7'h00, irq_n}, 8'h00);
    rd(FIFO_ADDR, 8'h89);
    rd(11'h122, 8'h01);
    rd(FIFO_ADDR, 8'h8c);
    chk({7'h00, irq_n}, 8'h01);
    chk(8'(falls - f0), 8'h02);
    set_tone('0);
    rd(FIFO_ADDR, 8'h89);
    rd(FIFO_ADDR, 8'h8c);
    rd(FIFO_ADDR, 8'h00);
    $display("interrupt test done");
  endtask

  task automatic t_masks;
    wr(MAIN_BASE + 11'h004, 8'h08);
    set_tone(32'h0000_0300);
    rd(FIFO_ADDR, 8'h89);
    rd(FIFO_ADDR, 8'h00);
    wr(MAIN_BASE + 11'h004, 8'h10);
    set_tone('0);
    rd(FIFO_ADDR, 8'h88);
    rd(FIFO_ADDR, 8'h00);
    wr(MAIN_BASE + 11'h004, 8'h00);
    wr(MAIN_BASE, 8'h20);
    set_tone(32'h0000_0001);
    chk({7'h00, irq_n}, 8'h01);
    wr(MAIN_BASE, 8'h00);
    chk({7'h00, irq_n}, 8'h00);
    rd(FIFO_ADDR, 8'h80);
    $display("mask test done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_ctrl();
    t_init();
    t_reset();
    t_pcm();
    t_depth();
    t_irq();
    t_masks();
    give_verdict();
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    failures++;
    $display("ERROR at %0t: run timed out", $time);
    give_verdict();
  end
endmodule
